// file: logic/lpsc_defines.vh
// Constants shared by the link PHY lane state controller.
`ifndef LPSC_DEFINES_VH
`define LPSC_DEFINES_VH

// Register byte addresses.
`define LPSC_ADR_CTRL      8'h00
`define LPSC_ADR_STATUS    8'h04
`define LPSC_CTRL_RESET    32'h0000_0800

// Control register fields.
`define LPSC_C_HPE         0
`define LPSC_C_STE         1
`define LPSC_C_GEN3        2
`define LPSC_C_ACSUP       3
`define LPSC_C_HPSUP       4
`define LPSC_C_OFFREQ      5
`define LPSC_C_SLP         7:6
`define LPSC_C_SLP_DEEP    7
`define LPSC_C_ILS         9:8
`define LPSC_C_WID         12:10
`define LPSC_C_FRQ         15:13

// Status register fields.
`define LPSC_S_STATE       9:0
`define LPSC_S_AC          10
`define LPSC_S_RELOCK      11
`define LPSC_S_DLL         12
`define LPSC_S_COMP        13

// Transmit drive state codes.
`define LPSC_TX_DIFF       3'h0
`define LPSC_TX_GND        3'h1
`define LPSC_TX_ACPROBE    3'h2
`define LPSC_TX_IDLE       3'h3
`define LPSC_TX_HIZ        3'h4

// Receive termination state codes.
`define LPSC_RX_CTAP       2'h0
`define LPSC_RX_DIFF       2'h1
`define LPSC_RX_GNDPROBE   2'h2
`define LPSC_RX_OFF        2'h3

// Lane layout: lane 0 clock, lane 1 control, lanes 2..9 data.
`define LPSC_LANES         10
`define LPSC_PAT_LANES     9
`define LPSC_ILS_WIDE      2'h1

// Link clock edges counted while the receive DLL relocks.
`define LPSC_RELOCK_EDGES  5'h10

`endif

// file: logic/lpsc_lane_ctrl.v
// Link PHY lane state controller with a classic Wishbone register slave.
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "lpsc_defines.vh"

// Operation
// R1: Full-active state carries normal link traffic.
// R2: Disconnected uses one of four sleep states.
// R3: Disconnected full-on keeps all lanes active.
// R4: Deeper sleep shuts more circuitry, longer exit.
// R5: Cold reset starts DC; AC detect otherwise.
// R6: Hot-plug off states: ground term, center-tap.
// R7: Without hot-plug, off receiver amplifier disabled.
// R8: First generation tristates only if enabled.
// R9: Non hot-plug transmitters unconstrained before power.
// R10: Hot-plug third generation grounds without power.
// R11: Compensation disabled while PHY powered off.
// R12: DLL relocks on width, deepest, frequency exit.
// R13: DLL relocks when leaving warm reset.
// R14: AC coupling optional; modes freely combinable.
// R15: High-skew sideband devices must support hot-plug.
// R16: Same training pattern for DC and AC.
// R17: Same pattern on every active lane.
// R18: Decoder starts with FIFO write pointer.
// R19: Training patterns bypass the scrambler.
// R20: Per-lane encoded transmit and receive states.
module lpsc_lane_ctrl (
    // Clock and reset
    input  wire        CLK,
    input  wire        RST_N,
    // Wishbone slave
    input  wire        WB_CYC_I,
    input  wire        WB_STB_I,
    input  wire        WB_WE_I,
    input  wire [7:0]  WB_ADR_I,
    input  wire [3:0]  WB_SEL_I,
    input  wire [31:0] WB_DAT_I,
    output reg  [31:0] WB_DAT_O,
    output reg         WB_ACK_O,
    // Sideband and link pins
    input  wire        POWER_GOOD,
    input  wire        LINK_STOP_N,
    input  wire        LINK_RESET_N,
    input  wire        LINK_CLK,
    input  wire        DC_COUPLED,
    // Training pattern and receiver start
    input  wire [9:0]  TRAIN_SYMBOL,
    input  wire        TRAIN_VALID,
    input  wire        FIFO_WR_START,
    // Lane and PHY controls
    output reg  [29:0] TX_LANE_STATE,
    output reg  [19:0] RX_LANE_STATE,
    output reg  [89:0] TRAIN_LANE_DATA,
    output reg         SCRAMBLE_BYPASS,
    output reg         DECODER_START,
    output reg         DLL_ENABLE,
    output reg         DLL_RELOCK,
    output reg         COMP_ENABLE
);

    localparam [9:0] ST_NOPWR  = 10'h001;
    localparam [9:0] ST_COLD   = 10'h002;
    localparam [9:0] ST_ACDET  = 10'h004;
    localparam [9:0] ST_WARM   = 10'h008;
    localparam [9:0] ST_ACTIVE = 10'h010;
    localparam [9:0] ST_LS0    = 10'h020;
    localparam [9:0] ST_LS1    = 10'h040;
    localparam [9:0] ST_LS2    = 10'h080;
    localparam [9:0] ST_LS3    = 10'h100;
    localparam [9:0] ST_OFF    = 10'h200;

    reg  [31:0] ctrl_q;
    reg  [9:0]  state_q;
    reg  [9:0]  state_d;
    reg         ac_q;
    reg         ac_d;
    reg  [4:0]  sync1_q;
    reg  [4:0]  sync2_q;
    reg         lclk_prev_q;
    reg  [2:0]  wid_entry_q;
    reg  [2:0]  frq_entry_q;
    reg         relock_req;
    reg  [4:0]  relock_cnt_q;
    wire        pg_s;
    wire        stop_n_s;
    wire        rst_n_s;
    wire        lclk_s;
    wire        dc_s;
    wire        lclk_rise;
    wire        wb_req;
    wire        sleeping;
    wire [8:0]  pat_active;

    // Two-stage synchronisers for every pin from outside the clock domain.
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else begin
            sync1_q <= {DC_COUPLED, LINK_CLK, LINK_RESET_N, LINK_STOP_N,
                        POWER_GOOD};
            sync2_q <= sync1_q;
        end
    end

    assign pg_s     = sync2_q[0];
    assign stop_n_s = sync2_q[1];
    assign rst_n_s  = sync2_q[2];
    assign lclk_s   = sync2_q[3];
    assign dc_s     = sync2_q[4];
    assign lclk_rise = lclk_s & ~lclk_prev_q;
    assign sleeping = |(state_q & (ST_LS0 | ST_LS1 | ST_LS2 | ST_LS3));

    // Transmit drive state for one lane in one PHY state.
    function [2:0] tx_code;
        input [9:0] st;
        input       is_clk;
        input       ac;
        input [31:0] c;
        begin
            case (st)
                ST_NOPWR:
                    if (ac || (c[`LPSC_C_GEN3] &&
                               (c[`LPSC_C_HPSUP] || c[`LPSC_C_ACSUP])))
                        tx_code = `LPSC_TX_GND; // [R10]
                    else
                        tx_code = `LPSC_TX_HIZ; // [R9]
                ST_ACDET: tx_code = `LPSC_TX_ACPROBE;
                ST_WARM:
                    tx_code = (ac && !is_clk) ? `LPSC_TX_IDLE
                                              : `LPSC_TX_DIFF;
                ST_LS1, ST_LS2:
                    if (is_clk && st == ST_LS1)
                        tx_code = `LPSC_TX_DIFF;
                    else if (ac || c[`LPSC_C_GEN3])
                        tx_code = `LPSC_TX_IDLE; // [R4]
                    else if (c[`LPSC_C_STE])
                        tx_code = `LPSC_TX_HIZ; // [R8]
                    else
                        tx_code = `LPSC_TX_DIFF; // [R8]
                ST_LS3, ST_OFF:
                    if (c[`LPSC_C_HPE] || ac)
                        tx_code = `LPSC_TX_GND; // [R6]
                    else
                        tx_code = `LPSC_TX_HIZ;
                default: tx_code = `LPSC_TX_DIFF; // [R1] [R3]
            endcase
        end
    endfunction

    // Receive termination state in one PHY state.
    function [1:0] rx_code;
        input [9:0] st;
        input       ac;
        input       hpe;
        begin
            case (st)
                ST_NOPWR: rx_code = `LPSC_RX_OFF;
                ST_COLD:  rx_code = `LPSC_RX_GNDPROBE;
                ST_ACDET: rx_code = `LPSC_RX_CTAP;
                ST_LS3, ST_OFF:
                    if (hpe)
                        rx_code = `LPSC_RX_CTAP; // [R6]
                    else
                        rx_code = `LPSC_RX_OFF; // [R7]
                default:
                    rx_code = ac ? `LPSC_RX_CTAP : `LPSC_RX_DIFF; // [R14]
            endcase
        end
    endfunction

    // Next PHY state from the synchronised sideband signals.
    always @* begin
        state_d = state_q;
        ac_d    = ac_q;
        if (!pg_s) begin
            state_d = ST_NOPWR;
            ac_d    = 1'b0;
        end else begin
            case (state_q)
                ST_NOPWR: begin
                    state_d = ST_COLD; // [R5]
                    ac_d    = 1'b0;
                end
                ST_COLD:
                    if (!dc_s) begin
                        if (ctrl_q[`LPSC_C_ACSUP]) begin
                            state_d = ST_ACDET; // [R5]
                            ac_d    = 1'b1;
                        end else begin
                            state_d = ST_OFF;
                        end
                    end else if (rst_n_s) begin
                        state_d = ST_ACTIVE;
                    end
                ST_ACDET:
                    if (rst_n_s)
                        state_d = ST_ACTIVE;
                ST_WARM:
                    if (rst_n_s)
                        state_d = ST_ACTIVE;
                ST_ACTIVE, ST_LS0, ST_LS1, ST_LS2, ST_LS3:
                    if (!rst_n_s)
                        state_d = ST_WARM; // [R2]
                    else if (ctrl_q[`LPSC_C_OFFREQ])
                        state_d = ST_OFF;
                    else if (stop_n_s)
                        state_d = ST_ACTIVE; // [R1]
                    else if (state_q == ST_ACTIVE)
                        case (ctrl_q[`LPSC_C_SLP]) // [R2]
                            2'h0: state_d = ST_LS0;
                            2'h1: state_d = ST_LS1;
                            2'h2: state_d = ST_LS2;
                            default: state_d = ST_LS3;
                        endcase
                ST_OFF:
                    if (!ctrl_q[`LPSC_C_OFFREQ] && stop_n_s)
                        state_d = rst_n_s ? ST_ACTIVE : ST_WARM;
                default: state_d = ST_NOPWR;
            endcase
        end
    end

    // Relock causes seen when the link leaves a stop or a reset.
    always @* begin
        relock_req = 1'b0;
        if (state_q == ST_WARM && state_d == ST_ACTIVE)
            relock_req = 1'b1; // [R13]
        if ((sleeping || state_q == ST_OFF) && state_d == ST_ACTIVE) begin
            if (state_q == ST_LS3 || state_q == ST_OFF)
                relock_req = 1'b1; // [R12]
            if (ctrl_q[`LPSC_C_WID] > wid_entry_q &&
                ctrl_q[`LPSC_C_ILS] == `LPSC_ILS_WIDE)
                relock_req = 1'b1; // [R12]
            if (ctrl_q[`LPSC_C_FRQ] != frq_entry_q)
                relock_req = 1'b1; // [R12]
            // Hot-plug links with a deep sleep select relock on every
            // stop exit, so that skewed sideband pins are tolerated.
            if (ctrl_q[`LPSC_C_HPE] && ctrl_q[`LPSC_C_SLP_DEEP])
                relock_req = 1'b1; // [R15]
        end
    end

    // PHY state, entry snapshots and DLL relock window.
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q      <= ST_NOPWR;
            ac_q         <= 1'b0;
            lclk_prev_q  <= 1'b0;
            wid_entry_q  <= 3'h0;
            frq_entry_q  <= 3'h0;
            relock_cnt_q <= 5'h00;
        end else begin
            state_q     <= state_d;
            ac_q        <= ac_d;
            lclk_prev_q <= lclk_s;
            if (state_q == ST_ACTIVE && state_d != ST_ACTIVE) begin
                wid_entry_q <= ctrl_q[`LPSC_C_WID];
                frq_entry_q <= ctrl_q[`LPSC_C_FRQ];
            end
            if (relock_req)
                relock_cnt_q <= `LPSC_RELOCK_EDGES;
            else if (state_q != ST_ACTIVE)
                relock_cnt_q <= 5'h00;
            else if (lclk_rise && relock_cnt_q != 5'h00)
                relock_cnt_q <= relock_cnt_q - 5'h01;
        end
    end

    // Active pattern lanes: control plus the data lanes of the width.
    genvar g;
    generate
        for (g = 0; g < `LPSC_PAT_LANES; g = g + 1) begin : g_act
            if (g == 0) begin : g_ctl
                assign pat_active[g] = 1'b1;
            end else begin : g_cad
                assign pat_active[g] =
                    (g - 1) < (2 << ctrl_q[`LPSC_C_WID]);
            end
        end
    endgenerate

    // Registered lane states and replicated training data.
    generate
        for (g = 0; g < `LPSC_LANES; g = g + 1) begin : g_lane
            always @(posedge CLK or negedge RST_N) begin
                if (!RST_N) begin
                    TX_LANE_STATE[3*g +: 3] <= `LPSC_TX_HIZ;
                    RX_LANE_STATE[2*g +: 2] <= `LPSC_RX_OFF;
                end else begin
                    TX_LANE_STATE[3*g +: 3] <=
                        tx_code(state_q, g == 0, ac_q, ctrl_q); // [R20]
                    RX_LANE_STATE[2*g +: 2] <=
                        rx_code(state_q, ac_q,
                                ctrl_q[`LPSC_C_HPE]); // [R20]
                end
            end
        end
        for (g = 0; g < `LPSC_PAT_LANES; g = g + 1) begin : g_pat
            always @(posedge CLK or negedge RST_N) begin
                if (!RST_N)
                    TRAIN_LANE_DATA[10*g +: 10] <= 10'h000;
                else if (TRAIN_VALID && pat_active[g] &&
                         state_q == ST_ACTIVE)
                    TRAIN_LANE_DATA[10*g +: 10] <= TRAIN_SYMBOL; // [R17]
                else
                    TRAIN_LANE_DATA[10*g +: 10] <= 10'h000;
            end
        end
    endgenerate

    // Coupling does not alter the pattern; it goes out unscrambled.
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            SCRAMBLE_BYPASS <= 1'b0;
            DECODER_START   <= 1'b0;
            DLL_ENABLE      <= 1'b0;
            DLL_RELOCK      <= 1'b0;
            COMP_ENABLE     <= 1'b0;
        end else begin
            SCRAMBLE_BYPASS <= TRAIN_VALID &&
                               state_q == ST_ACTIVE; // [R16] [R19]
            DECODER_START   <= FIFO_WR_START; // [R18]
            DLL_ENABLE      <= ~|(state_d & (ST_NOPWR | ST_LS3 |
                                             ST_OFF)); // [R4]
            DLL_RELOCK      <= relock_req ||
                               (relock_cnt_q != 5'h00 &&
                                !(lclk_rise &&
                                  relock_cnt_q == 5'h01)); // [R12]
            COMP_ENABLE     <= ~|(state_d & (ST_NOPWR |
                                             ST_OFF)); // [R11]
        end
    end

    // Wishbone classic slave: one wait state, ack for one cycle.
    assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;

    always @(posedge CLK or negedge RST_N) begin : p_wb
        integer b;
        if (!RST_N) begin
            ctrl_q   <= `LPSC_CTRL_RESET;
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= wb_req;
            if (wb_req && WB_WE_I && WB_ADR_I == `LPSC_ADR_CTRL) begin
                for (b = 0; b < 4; b = b + 1)
                    if (WB_SEL_I[b])
                        ctrl_q[8*b +: 8] <= WB_DAT_I[8*b +: 8];
            end
            if (wb_req && !WB_WE_I) begin
                case (WB_ADR_I)
                    `LPSC_ADR_CTRL:   WB_DAT_O <= ctrl_q;
                    `LPSC_ADR_STATUS: begin
                        WB_DAT_O <= 32'h0000_0000;
                        WB_DAT_O[`LPSC_S_STATE]  <= state_q;
                        WB_DAT_O[`LPSC_S_AC]     <= ac_q;
                        WB_DAT_O[`LPSC_S_RELOCK] <= DLL_RELOCK;
                        WB_DAT_O[`LPSC_S_DLL]    <= DLL_ENABLE;
                        WB_DAT_O[`LPSC_S_COMP]   <= COMP_ENABLE;
                    end
                    default: WB_DAT_O <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // lpsc_lane_ctrl

// file: tb/lpsc_far_port.sv
// Far-side link port model: link clock and coupling level.
`timescale 1ns/100ps
module lpsc_far_port (
    // Bench controls
    input  wire logic run,
    input  wire logic dc_drive,
    // Link pins
    output logic      LINK_CLK,
    output logic      DC_COUPLED
);
    initial LINK_CLK = 1'b0;
    // The clock stands still while the link is not running.
    always begin
        #40;
        LINK_CLK = run ? ~LINK_CLK : 1'b0;
    end
    assign DC_COUPLED = dc_drive;
endmodule // lpsc_far_port

// file: tb/lpsc_lane_ctrl_checker.sv
// Port checker for the link PHY lane state controller.
`timescale 1ns/100ps
module lpsc_lane_ctrl_checker (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RST_N,
    // Bus and sideband
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_ACK_O,
    input wire logic        POWER_GOOD,
    // Training
    input wire logic [9:0]  TRAIN_SYMBOL,
    input wire logic        TRAIN_VALID,
    input wire logic        FIFO_WR_START,
    // Lane and PHY controls
    input wire logic [29:0] TX_LANE_STATE,
    input wire logic [89:0] TRAIN_LANE_DATA,
    input wire logic        SCRAMBLE_BYPASS,
    input wire logic        DECODER_START,
    input wire logic        DLL_ENABLE,
    input wire logic        DLL_RELOCK,
    input wire logic        COMP_ENABLE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic bad_tx;
    always @* begin
        bad_tx = 1'b0;
        for (int i = 0; i < 10; i++)
            if (TX_LANE_STATE[3*i +: 3] > 3'h4 ||
                (i > 0 && TX_LANE_STATE[3*i +: 3] != TX_LANE_STATE[5:3]))
                bad_tx = 1'b1;
    end
    sequence s_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_pg_gone;
        !POWER_GOOD [*6];
    endsequence
    property p_ack_next;
        s_req |=> WB_ACK_O;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("bus ack missing");
    property p_dec_start;
        1'b1 |=> DECODER_START == $past(FIFO_WR_START);
    endproperty
    a_dec_start: assert property (p_dec_start)
        else $error("decoder start off");
    property p_train_ctl;
        SCRAMBLE_BYPASS |-> TRAIN_LANE_DATA[9:0] == $past(TRAIN_SYMBOL);
    endproperty
    a_train_ctl: assert property (p_train_ctl)
        else $error("control lane symbol wrong");
    property p_train_same;
        SCRAMBLE_BYPASS |-> TRAIN_LANE_DATA[19:10] == TRAIN_LANE_DATA[9:0];
    endproperty
    a_train_same: assert property (p_train_same)
        else $error("lanes differ");
    property p_bypass_cause;
        SCRAMBLE_BYPASS |-> $past(TRAIN_VALID);
    endproperty
    a_bypass_cause: assert property (p_bypass_cause)
        else $error("bypass without training");
    property p_pg_off;
        s_pg_gone |=> !DLL_ENABLE && !COMP_ENABLE;
    endproperty
    a_pg_off: assert property (p_pg_off)
        else $error("dll or comp on without power");
    property p_tx_legal;
        !bad_tx;
    endproperty
    a_tx_legal: assert property (p_tx_legal)
        else $error("illegal transmit code");
    property p_relock_hold;
        $rose(DLL_RELOCK) |=> DLL_RELOCK [*8];
    endproperty
    a_relock_hold: assert property (p_relock_hold)
        else $error("relock too short");
endmodule // lpsc_lane_ctrl_checker

// file: tb/test_link_phy_lane_state_control.sv
// Self-checking bench for the link PHY lane state controller.
`timescale 1ns/100ps
`include "lpsc_defines.vh"
module test_link_phy_lane_state_control;
    logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
    logic [7:0]  adr = 0;
    logic [31:0] wdat = 0, rdat, exp_q[$];
    logic        ack, pg = 0, stop_n = 1, lrst_n = 0, run = 0, dc = 1;
    logic        link_clk, dc_pin, tvalid = 0, fstart = 0;
    logic [9:0]  sym = 10'h032;
    logic [29:0] tx;
    logic [19:0] rx;
    logic [89:0] tdata;
    logic        byp, dstart, dll_en, relock, comp_en;
    int          errors = 0, checks = 0, ticks = 0;

    lpsc_lane_ctrl lpsc_lane_ctrl_inst (
        .CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .POWER_GOOD(pg),
        .LINK_STOP_N(stop_n), .LINK_RESET_N(lrst_n),
        .LINK_CLK(link_clk), .DC_COUPLED(dc_pin), .TRAIN_SYMBOL(sym),
        .TRAIN_VALID(tvalid), .FIFO_WR_START(fstart),
        .TX_LANE_STATE(tx), .RX_LANE_STATE(rx), .TRAIN_LANE_DATA(tdata),
        .SCRAMBLE_BYPASS(byp), .DECODER_START(dstart),
        .DLL_ENABLE(dll_en), .DLL_RELOCK(relock), .COMP_ENABLE(comp_en));
    lpsc_far_port lpsc_far_port_inst (.run(run), .dc_drive(dc),
        .LINK_CLK(link_clk), .DC_COUPLED(dc_pin));

    initial forever #5 clk = ~clk;

    function automatic logic [9:0] lfsr(input logic [9:0] v);
        return {v[8:0], v[9] ^ v[6]};
    endfunction
    task automatic cmp(input string nm, input logic [89:0] e, g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic lanes(input logic [2:0] t, input logic [1:0] r);
        cmp("tx lanes", {60'h0, {10{t}}}, {60'h0, tx});
        cmp("rx lanes", {70'h0, {10{r}}}, {70'h0, rx});
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) errors++;
        cyc <= 0;
        stb <= 0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(0, a, 32'h0);
    endtask
    task automatic train();
        repeat (4) begin
            sym <= lfsr(sym);
            fstart <= sym[0];
            tvalid <= 1;
            wait_n(2);
            cmp("train data", {9{sym}}, tdata);
            cmp("bypass", 90'h1, {89'h0, byp});
        end
        tvalid <= 0;
    endtask
    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0)
                errors++;
            else
                cmp("read data", exp_q.pop_front(), rdat);
        end
    end
    always @(posedge clk) begin
        ticks++;
        if (ticks == 20000) begin
            errors++;
            wrap_up();
        end
    end

    initial begin
        wait_n(8);
        lanes(`LPSC_TX_HIZ, `LPSC_RX_OFF);
        wait_n(8);
        rst_n <= 1;
        wait_n(6);
        lanes(`LPSC_TX_HIZ, `LPSC_RX_OFF);
        rd(`LPSC_ADR_CTRL, `LPSC_CTRL_RESET);
        wb(1, 8'h08, 32'hffff_ffff);
        rd(8'h08, 32'h0);
        wb(1, `LPSC_ADR_STATUS, 32'hffff_ffff);
        rd(`LPSC_ADR_STATUS, 32'h0000_0001);
        done("registers");
        pg <= 1;
        lrst_n <= 1;
        run <= 1;
        wait_n(12);
        lanes(`LPSC_TX_DIFF, `LPSC_RX_DIFF);
        rd(`LPSC_ADR_STATUS, 32'h0000_3010);
        train();
        done("power up and training");
        for (int s = 0; s < 2; s++) begin
            wb(1, `LPSC_ADR_CTRL, 32'h0880 | (s << 1));
            stop_n <= 0;
            wait_n(8);
            lanes(s ? `LPSC_TX_HIZ : `LPSC_TX_DIFF, `LPSC_RX_DIFF);
            stop_n <= 1;
            wait_n(8);
            lanes(`LPSC_TX_DIFF, `LPSC_RX_DIFF);
            cmp("dll relock", 90'h0, {89'h0, relock});
        end
        wb(1, `LPSC_ADR_CTRL, 32'h0881);
        stop_n <= 0;
        wait_n(8);
        stop_n <= 1;
        wait_n(8);
        cmp("dll relock", 90'h1, {89'h0, relock});
        wait_n(200);
        done("light stop");
        wb(1, `LPSC_ADR_CTRL, 32'h08c1);
        stop_n <= 0;
        wait_n(8);
        lanes(`LPSC_TX_GND, `LPSC_RX_CTAP);
        cmp("dll enable", 90'h0, {89'h0, dll_en});
        stop_n <= 1;
        wait_n(8);
        cmp("dll relock", 90'h1, {89'h0, relock});
        wait_n(200);
        cmp("dll relock", 90'h0, {89'h0, relock});
        lrst_n <= 0;
        wait_n(8);
        lanes(`LPSC_TX_DIFF, `LPSC_RX_DIFF);
        lrst_n <= 1;
        wait_n(8);
        cmp("dll relock", 90'h1, {89'h0, relock});
        wait_n(200);
        done("deepest sleep and warm reset");
        wb(1, `LPSC_ADR_CTRL, 32'h0820);
        wait_n(8);
        lanes(`LPSC_TX_HIZ, `LPSC_RX_OFF);
        cmp("comp enable", 90'h0, {89'h0, comp_en});
        wb(1, `LPSC_ADR_CTRL, 32'h0800);
        wait_n(8);
        rd(`LPSC_ADR_STATUS, 32'h0000_3810);
        done("phy_powered_off");
        wb(1, `LPSC_ADR_CTRL, 32'h0814);
        pg <= 0;
        wait_n(8);
        lanes(`LPSC_TX_GND, `LPSC_RX_OFF);
        wb(1, `LPSC_ADR_CTRL, 32'h080c);
        wait_n(4);
        lanes(`LPSC_TX_GND, `LPSC_RX_OFF);
        lrst_n <= 0;
        dc <= 0;
        pg <= 1;
        wait_n(10);
        lanes(`LPSC_TX_ACPROBE, `LPSC_RX_CTAP);
        lrst_n <= 1;
        wait_n(8);
        lanes(`LPSC_TX_DIFF, `LPSC_RX_CTAP);
        train();
        done("no power and ac detect");
        wrap_up();
    end
endmodule // test_link_phy_lane_state_control

bind lpsc_lane_ctrl lpsc_lane_ctrl_checker lpsc_lane_ctrl_checker_inst (
    .CLK, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_ACK_O, .POWER_GOOD,
    .TRAIN_SYMBOL, .TRAIN_VALID, .FIFO_WR_START, .TX_LANE_STATE,
    .TRAIN_LANE_DATA, .SCRAMBLE_BYPASS, .DECODER_START, .DLL_ENABLE,
    .DLL_RELOCK, .COMP_ENABLE);
